//--- src/scr_regs.vh
`ifndef SCR_REGS_VH
`define SCR_REGS_VH

// register addresses
`define SCR_ADDR_CFG_RD 7'h00
`define SCR_ADDR_CFG_WR 7'h00
`define SCR_ADDR_TEMP_LSB 7'h01
`define SCR_ADDR_LOWER_TRIP_LIMIT_MSB 7'h06
`define SCR_ADDR_THIGH_LSB 7'h03
`define SCR_INVALID_BYTE 8'hff

// config/status bit positions
`define SCR_BIT_ZERO 7
`define SCR_BIT_NV_SEL 6
`define SCR_BIT_NV_BUSY 5
`define SCR_BIT_ONESHOT 4
`define SCR_BIT_TMODE 3
`define SCR_BIT_RES_HI 2
`define SCR_BIT_RES_LO 1
`define SCR_BIT_SD 0

// power-up and factory values
`define SCR_RST_NV_SEL 1'b0
`define SCR_RST_NV_BUSY 1'b0
`define SCR_RST_ONESHOT 1'b0
`define SCR_FACT_TMODE 1'b0
`define SCR_FACT_RES 2'h0
`define SCR_FACT_RES_HI 1'b0
`define SCR_FACT_RES_LO 1'b0
`define SCR_FACT_SD 1'b1

// resolution codes
`define SCR_RES_9 2'h0
`define SCR_RES_10 2'h1
`define SCR_RES_11 2'h2
`define SCR_RES_12 2'h3

// timing: core clock in kHz, times in ms
`define SCR_CLK_KHZ 40000
`define SCR_CONV_MS_9 25
`define SCR_CONV_MS_10 50
`define SCR_CONV_MS_11 100
`define SCR_CONV_MS_12 200
`define SCR_NV_WR_MS 10

// serial byte framing
`define SCR_BIT_CNT_LAST 3'h7
`define SCR_BIT_CNT_FIRST 3'h0

`endif

//--- src/scr_sync.v
`timescale 1ns/1ps
module scr_sync
(
   input wire clk_in,
   input wire nrst_in,
   input wire d_in,
   output reg q_out
);

reg s1;
reg s2;
reg s3;

// three stages; level taken once stages two and three agree
always @(posedge clk_in or negedge nrst_in)
begin
   if (!nrst_in)
   begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q_out <= 1'b0;
   end
   else
   begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
         q_out <= s3;
   end
end

endmodule

//--- src/scr_config_status.v
`timescale 1ns/1ps
`include "scr_regs.vh"
module scr_config_status
#(
   parameter CNT_W = 23,
   parameter [31:0] CONV_CYC_9 = `SCR_CONV_MS_9 * `SCR_CLK_KHZ,
   parameter [31:0] CONV_CYC_10 = `SCR_CONV_MS_10 * `SCR_CLK_KHZ,
   parameter [31:0] CONV_CYC_11 = `SCR_CONV_MS_11 * `SCR_CLK_KHZ,
   parameter [31:0] CONV_CYC_12 = `SCR_CONV_MS_12 * `SCR_CLK_KHZ,
   parameter [31:0] NV_WR_CYC = `SCR_NV_WR_MS * `SCR_CLK_KHZ
)
(
   input wire core_clk_in,
   input wire nrst_in,
   input wire ce_in,
   input wire sclk_in,
   input wire sdi_in,
   input wire interface_select_in,
   input wire [7:0] ext_rd_data_in,
   input wire trip_level_in,
   input wire trip_event_in,
   output reg sdo_out,
   output reg sdo_oe_out,
   output reg [6:0] ext_addr_out,
   output reg ext_wr_strobe_out,
   output reg [7:0] ext_wr_data_out,
   output reg conv_active_out,
   output reg conv_done_out,
   output reg low_power_out,
   output reg [1:0] resolution_out,
   output reg thermostat_mode_out,
   output reg thermostat_alert_output_out,
   output reg [3:0] nv_image_out
);

localparam [2:0] S_IDLE = 3'b001;
localparam [2:0] S_ADDR = 3'b010;
localparam [2:0] S_DATA = 3'b100;
localparam [1:0] C_IDLE = 2'b01;
localparam [1:0] C_RUN = 2'b10;

// pin synchronisers
wire [3:0] pin_raw;
wire [3:0] pin_sync;
assign pin_raw = {interface_select_in, sdi_in, sclk_in, ce_in};

genvar gi;
generate
   for (gi = 0; gi < 4; gi = gi + 1)
   begin : g_sync
      scr_sync u_sync
      (
         .clk_in(core_clk_in),
         .nrst_in(nrst_in),
         .d_in(pin_raw[gi]),
         .q_out(pin_sync[gi])
      );
   end
endgenerate

wire ce_s;
wire sclk_s;
wire sdi_s;
wire mode_s;
assign ce_s = pin_sync[0];
assign sclk_s = pin_sync[1];
assign sdi_s = pin_sync[2];
assign mode_s = pin_sync[3];

// configuration state
reg nv_store_select;
reg nv_write_busy;
reg single_conversion_trigger;
reg thermostat_mode_select;
reg resolution_sel_hi;
reg resolution_sel_lo;
reg shutdown_select;
reg [3:0] nv_pending;
reg [31:0] nv_cnt;

// serial state
reg [2:0] ser_state;
reg ce_d;
reg sclk_d;
reg idle_level;
reg spi_mode;
reg is_write;
reg [2:0] bit_cnt;
reg [7:0] rx;
reg [7:0] tx;
reg [6:0] addr;

// conversion state
reg [1:0] conv_state;
reg [CNT_W-1:0] conv_cnt;

wire [7:0] cfg_byte;
assign cfg_byte = {1'b0, nv_store_select, nv_write_busy,
   single_conversion_trigger, thermostat_mode_select,
   resolution_sel_hi, resolution_sel_lo, shutdown_select};

wire sclk_edge;
wire latch_edge;
wire shift_edge;
assign sclk_edge = (sclk_s != sclk_d) && (ser_state != S_IDLE);
assign latch_edge = sclk_edge &&
   (spi_mode ? (sclk_s == idle_level) : sclk_s);
assign shift_edge = sclk_edge &&
   (spi_mode ? (sclk_s != idle_level) : !sclk_s);

wire [7:0] next_rx;
assign next_rx = spi_mode ? {rx[6:0], sdi_s} : {sdi_s, rx[7:1]};
wire byte_done;
assign byte_done = latch_edge && (bit_cnt == `SCR_BIT_CNT_LAST);

wire addr_valid;
assign addr_valid = (addr <= `SCR_ADDR_LOWER_TRIP_LIMIT_MSB);

reg [7:0] rd_byte;
always @*
begin
   if (addr == `SCR_ADDR_CFG_RD)
      rd_byte = cfg_byte;
   else if (addr_valid)
      rd_byte = ext_rd_data_in;
   else
      rd_byte = `SCR_INVALID_BYTE;
end

wire rd_start;
assign rd_start = (ser_state == S_DATA) && !is_write && shift_edge &&
   (bit_cnt == `SCR_BIT_CNT_FIRST);
wire rd_clear;
assign rd_clear = rd_start && addr_valid;
wire wr_done;
assign wr_done = (ser_state == S_DATA) && is_write && byte_done;
wire cfg_wr;
assign cfg_wr = wr_done && (addr == `SCR_ADDR_CFG_WR);
wire trip_wr;
assign trip_wr = wr_done && (addr >= `SCR_ADDR_THIGH_LSB) &&
   (addr <= `SCR_ADDR_LOWER_TRIP_LIMIT_MSB);

// serial slave, alive in every conversion state
always @(posedge core_clk_in or negedge nrst_in)
begin
   if (!nrst_in)
   begin
      ser_state <= S_IDLE;
      ce_d <= 1'b0;
      sclk_d <= 1'b0;
      idle_level <= 1'b0;
      spi_mode <= 1'b0;
      is_write <= 1'b0;
      bit_cnt <= `SCR_BIT_CNT_FIRST;
      rx <= 8'h00;
      tx <= 8'h00;
      addr <= 7'h00;
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
      ext_addr_out <= 7'h00;
      ext_wr_strobe_out <= 1'b0;
      ext_wr_data_out <= 8'h00;
   end
   else
   begin
      ce_d <= ce_s;
      sclk_d <= sclk_s;
      ext_wr_strobe_out <= 1'b0;
      ext_addr_out <= addr;
      case (ser_state)
         S_IDLE:
         begin
            sdo_oe_out <= 1'b0;
            bit_cnt <= `SCR_BIT_CNT_FIRST;
            if (ce_s && !ce_d)
            begin
               idle_level <= sclk_s;
               spi_mode <= mode_s;
               ser_state <= S_ADDR;
            end
         end
         S_ADDR:
         begin
            if (latch_edge)
            begin
               rx <= next_rx;
               bit_cnt <= bit_cnt + 3'h1;
            end
            if (byte_done)
            begin
               addr <= next_rx[6:0];
               is_write <= next_rx[7];
               ser_state <= S_DATA;
            end
         end
         S_DATA:
         begin
            if (latch_edge)
            begin
               rx <= next_rx;
               bit_cnt <= bit_cnt + 3'h1;
            end
            if (rd_start)
            begin
               sdo_oe_out <= 1'b1;
               sdo_out <= spi_mode ? rd_byte[7] : rd_byte[0];
               tx <= spi_mode ? {rd_byte[6:0], 1'b0} :
                  {1'b0, rd_byte[7:1]};
            end
            else if (shift_edge && !is_write)
            begin
               sdo_out <= spi_mode ? tx[7] : tx[0];
               tx <= spi_mode ? {tx[6:0], 1'b0} : {1'b0, tx[7:1]};
            end
            if (byte_done)
               addr <= addr + 7'h01;
            if (trip_wr)
            begin
               ext_wr_strobe_out <= 1'b1;
               ext_wr_data_out <= next_rx;
            end
         end
         default:
            ser_state <= S_IDLE;
      endcase
      if (!ce_s)
      begin
         ser_state <= S_IDLE;
         sdo_oe_out <= 1'b0;
      end
   end
end

// configuration register, one-shot, EEPROM commit
wire nv_commit;
assign nv_commit = (cfg_wr && nv_store_select) || trip_wr;
wire conv_finish;
assign conv_finish = (conv_state == C_RUN) && (conv_cnt == {CNT_W{1'b0}});
wire oneshot_set;
assign oneshot_set = cfg_wr && shutdown_select &&
   next_rx[`SCR_BIT_ONESHOT];
wire sd_enter;
assign sd_enter = cfg_wr && !shutdown_select && next_rx[`SCR_BIT_SD];

always @(posedge core_clk_in or negedge nrst_in)
begin
   if (!nrst_in)
   begin
      nv_store_select <= `SCR_RST_NV_SEL;
      nv_write_busy <= `SCR_RST_NV_BUSY;
      single_conversion_trigger <= `SCR_RST_ONESHOT;
      thermostat_mode_select <= `SCR_FACT_TMODE;
      resolution_sel_hi <= `SCR_FACT_RES_HI;
      resolution_sel_lo <= `SCR_FACT_RES_LO;
      shutdown_select <= `SCR_FACT_SD;
      nv_pending <= {`SCR_FACT_TMODE, `SCR_FACT_RES, `SCR_FACT_SD};
      nv_image_out <= {`SCR_FACT_TMODE, `SCR_FACT_RES, `SCR_FACT_SD};
      nv_cnt <= 32'h0;
   end
   else
   begin
      if (cfg_wr)
      begin
         // zero and busy bits not writable
         nv_store_select <= next_rx[`SCR_BIT_NV_SEL];
         thermostat_mode_select <= next_rx[`SCR_BIT_TMODE];
         resolution_sel_hi <= next_rx[`SCR_BIT_RES_HI];
         resolution_sel_lo <= next_rx[`SCR_BIT_RES_LO];
         shutdown_select <= next_rx[`SCR_BIT_SD];
      end
      if (oneshot_set)
         single_conversion_trigger <= 1'b1;
      else if (conv_finish)
         single_conversion_trigger <= 1'b0;
      if (nv_commit)
      begin
         nv_write_busy <= 1'b1;
         nv_cnt <= NV_WR_CYC - 32'h1;
         if (cfg_wr)
            nv_pending <= {next_rx[`SCR_BIT_TMODE],
               next_rx[`SCR_BIT_RES_HI], next_rx[`SCR_BIT_RES_LO],
               next_rx[`SCR_BIT_SD]};
         else
            nv_pending <= {thermostat_mode_select,
               resolution_sel_hi, resolution_sel_lo, shutdown_select};
      end
      else if (nv_write_busy)
      begin
         if (nv_cnt == 32'h0)
         begin
            nv_write_busy <= 1'b0;
            nv_image_out <= nv_pending;
         end
         else
            nv_cnt <= nv_cnt - 32'h1;
      end
   end
end

// conversion timing per resolution
reg [31:0] sel_cyc;
always @*
begin
   case ({resolution_sel_hi, resolution_sel_lo})
      `SCR_RES_9: sel_cyc = CONV_CYC_9;
      `SCR_RES_10: sel_cyc = CONV_CYC_10;
      `SCR_RES_11: sel_cyc = CONV_CYC_11;
      `SCR_RES_12: sel_cyc = CONV_CYC_12;
      default: sel_cyc = CONV_CYC_9;
   endcase
end
wire [31:0] sel_cnt;
assign sel_cnt = sel_cyc - 32'h1;

always @(posedge core_clk_in or negedge nrst_in)
begin
   if (!nrst_in)
   begin
      conv_state <= C_IDLE;
      conv_cnt <= {CNT_W{1'b0}};
      conv_active_out <= 1'b0;
      conv_done_out <= 1'b0;
      low_power_out <= 1'b1;
   end
   else
   begin
      conv_done_out <= 1'b0;
      case (conv_state)
         C_IDLE:
         begin
            // continuous or a pending one-shot
            if (!shutdown_select || single_conversion_trigger)
            begin
               conv_state <= C_RUN;
               conv_cnt <= sel_cnt[CNT_W-1:0];
               conv_active_out <= 1'b1;
               low_power_out <= 1'b0;
            end
            else
               low_power_out <= 1'b1;
         end
         C_RUN:
         begin
            // shutdown does not abort a running conversion
            if (conv_finish)
            begin
               conv_done_out <= 1'b1;
               conv_active_out <= 1'b0;
               conv_state <= C_IDLE;
            end
            else
               conv_cnt <= conv_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
         end
         default:
            conv_state <= C_IDLE;
      endcase
   end
end

// alert output and mode/resolution outputs
always @(posedge core_clk_in or negedge nrst_in)
begin
   if (!nrst_in)
   begin
      thermostat_alert_output_out <= 1'b0;
      thermostat_mode_out <= `SCR_FACT_TMODE;
      resolution_out <= `SCR_FACT_RES;
   end
   else
   begin
      thermostat_mode_out <= thermostat_mode_select;
      resolution_out <= {resolution_sel_hi, resolution_sel_lo};
      if (!thermostat_mode_select)
         thermostat_alert_output_out <= trip_level_in;
      else if (trip_event_in)
         thermostat_alert_output_out <= 1'b1;
      else if (rd_clear || sd_enter)
         thermostat_alert_output_out <= 1'b0;
   end
end

endmodule

//--- test/scr_host.sv
`timescale 1ns/1ps
module scr_host
(
   input wire mode_in,
   input wire sdo_in,
   input wire sdo_oe_in,
   output reg ce_out,
   output reg sclk_out,
   output wire sdi_out
);
   reg drv = 1'b1;
   reg hd = 1'b0;
   reg pol = 1'b0;
   // released shared line shows inverse of last bit
   assign sdi_out = (!mode_in && sdo_oe_in) ? sdo_in : (drv ? hd : ~hd);
   initial
   begin
      ce_out = 1'b0;
      sclk_out = 1'b0;
   end
   // address byte then one data byte, clock idles at pol
   task xfer(input [7:0] a, input [7:0] d, output [7:0] q);
      reg [15:0] st;
      reg [8:0] s;
      integer i;
   begin
      for (i = 0; i < 8; i = i + 1)
      begin
         st[i] = mode_in ? a[7-i] : a[i];
         st[i+8] = mode_in ? d[7-i] : d[i];
      end
      #5;
      hd = st[0];
      ce_out = 1'b1;
      #200;
      for (i = 0; i < 16; i = i + 1)
      begin
         sclk_out = ~pol;
         #50 sclk_out = pol;
         #75 hd = st[(i+1)%16];
         if (i == 7)
            drv = a[7];
         #75;
         if (i > 6)
            s[i-7] = mode_in ? sdo_in : sdi_out;
      end
      ce_out = 1'b0;
      drv = 1'b1;
      for (i = 0; i < 8; i = i + 1)
         q[mode_in ? 7-i : i] = s[mode_in ? i+1 : i];
      #395;
   end
   endtask
   // set the idle clock level between frames
   task idle(input p);
   begin
      #5;
      pol = p;
      sclk_out = p;
      #20;
   end
   endtask
endmodule

//--- test/scr_config_status_checker.sv
`timescale 1ns/1ps
module scr_config_status_checker
(
   input wire core_clk_in,
   input wire nrst_in,
   input wire ce_in,
   input wire trip_level_in,
   input wire trip_event_in,
   input wire sdo_oe_out,
   input wire ext_wr_strobe_out,
   input wire conv_active_out,
   input wire conv_done_out,
   input wire low_power_out,
   input wire [1:0] resolution_out,
   input wire thermostat_mode_out,
   input wire thermostat_alert_output_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!nrst_in);
   sequence ce_idle;
      !ce_in [*8];
   endsequence
   sequence int_mode;
      thermostat_mode_out && $past(thermostat_mode_out);
   endsequence
   idle_power_a: assert property (
      low_power_out |-> !conv_active_out)
      else $error("low power during conversion");
   conv_src_a: assert property (
      conv_done_out |-> $past(conv_active_out))
      else $error("result without conversion");
   done_pulse_a: assert property (
      conv_done_out |=> !conv_done_out)
      else $error("done pulse too long");
   strobe_pulse_a: assert property (
      ext_wr_strobe_out |=> !ext_wr_strobe_out)
      else $error("write strobe too long");
   stable_cfg_a: assert property (
      ce_idle |=> $stable({resolution_out, thermostat_mode_out}))
      else $error("config changed outside frame");
   oe_frame_a: assert property (
      ce_idle |-> !sdo_oe_out)
      else $error("output driven outside frame");
   cmp_follow_a: assert property (
      !thermostat_mode_out && !$past(thermostat_mode_out) |->
      thermostat_alert_output_out == $past(trip_level_in))
      else $error("comparator alert wrong");
   int_set_a: assert property (
      thermostat_mode_out && trip_event_in |=>
      thermostat_alert_output_out)
      else $error("alert not set");
   int_rise_a: assert property (
      int_mode ##0 $rose(thermostat_alert_output_out) |->
      $past(trip_event_in))
      else $error("alert rose without event");
endmodule
bind scr_config_status scr_config_status_checker u_chk (.*);

//--- test/sensor_config_status_register_test.sv
`timescale 1ns/1ps
module sensor_config_status_register_test;
   reg clk;
   reg nrst = 1'b0;
   reg mode = 1'b1;
   reg lvl = 1'b0;
   reg evt = 1'b0;
   wire ce, sclk, sdi, sdo, oe, strb, act, done, lp, tm, alrt;
   wire [6:0] addr;
   wire [7:0] wd;
   wire [1:0] res;
   wire [3:0] nvi;
   integer errors = 0;
   integer cmp_count = 0;
   integer cyc = 0;
   integer run = 0;
   integer clen = 0;
   integer ndone = 0;
   reg [7:0] q;
   reg [7:0] lastwd = 8'h00;
   reg [6:0] lastad = 7'h00;
   reg [7:0] rdv = 8'h5c;
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   scr_config_status #(.CONV_CYC_9(20), .CONV_CYC_10(40),
      .CONV_CYC_11(80), .CONV_CYC_12(160), .NV_WR_CYC(400)) u_dut
   (
      .core_clk_in(clk),
      .nrst_in(nrst),
      .ce_in(ce),
      .sclk_in(sclk),
      .sdi_in(sdi),
      .interface_select_in(mode),
      .ext_rd_data_in(rdv),
      .trip_level_in(lvl),
      .trip_event_in(evt),
      .sdo_out(sdo),
      .sdo_oe_out(oe),
      .ext_addr_out(addr),
      .ext_wr_strobe_out(strb),
      .ext_wr_data_out(wd),
      .conv_active_out(act),
      .conv_done_out(done),
      .low_power_out(lp),
      .resolution_out(res),
      .thermostat_mode_out(tm),
      .thermostat_alert_output_out(alrt),
      .nv_image_out(nvi)
   );
   scr_host u_host
   (
      .mode_in(mode),
      .sdo_in(sdo),
      .sdo_oe_in(oe),
      .ce_out(ce),
      .sclk_out(sclk),
      .sdi_out(sdi)
   );
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      run <= act ? run + 1 : 0;
      if (done)
      begin
         clen <= run;
         ndone <= ndone + 1;
      end
      if (strb)
      begin
         lastwd <= wd;
         lastad <= addr;
      end
      if (cyc == 20000)
      begin
         errors = errors + 1;
         end_of_test;
      end
   end
   task chk(input [7:0] got, input [7:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task wt(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task wr(input [7:0] v);
      u_host.xfer(8'h80, v, q);
   endtask
   task rdc(input [7:0] a, input [7:0] x);
   begin
      u_host.xfer(a, 8'h00, q);
      chk(q, x);
   end
   endtask
   task t_reset;
   begin
      rdc(8'h00, 8'h01);
      chk({7'h0, lp}, 8'h01);
      wr(8'ha1);
      rdc(8'h00, 8'h01);
      rdc(8'h07, 8'hff);
      $display("test reset done");
   end
   endtask
   task t_res;
      integer r;
      integer n;
      reg ok;
   begin
      for (r = 0; r < 4; r = r + 1)
      begin
         n = ndone;
         wr({4'h1, 1'b0, r[1:0], 1'b1});
         wt(200);
         chk(8'(ndone - n), 8'h01);
         chk({6'h0, res}, {6'h0, r[1:0]});
         ok = clen >= (20 << r) - 1 && clen <= (20 << r) + 1;
         chk({7'h0, ok}, 8'h01);
         rdc(8'h00, {5'h0, r[1:0], 1'b1});
      end
      $display("test resolution done");
   end
   endtask
   task t_cont;
      integer n;
   begin
      wr(8'h00);
      n = ndone;
      wt(100);
      chk({7'h0, lp}, 8'h00);
      chk({7'h0, ndone - n > 2}, 8'h01);
      wr(8'h10);
      rdc(8'h00, 8'h00);
      wr(8'h01);
      wt(40);
      chk({7'h0, lp}, 8'h01);
      chk({7'h0, clen >= 19 && clen <= 21}, 8'h01);
      $display("test continuous done");
   end
   endtask
   task t_nv;
   begin
      wr(8'h47);
      wt(500);
      chk({4'h0, nvi}, 8'h01);
      wr(8'h4b);
      rdc(8'h00, 8'h6b);
      wt(500);
      chk({4'h0, nvi}, 8'h0b);
      rdc(8'h00, 8'h4b);
      $display("test store done");
   end
   endtask
   task t_alert;
   begin
      @(posedge clk) evt <= 1'b1;
      lvl <= 1'b1;
      @(posedge clk) evt <= 1'b0;
      wt(2);
      chk({7'h0, alrt}, 8'h01);
      rdc(8'h01, 8'h5c);
      chk({7'h0, alrt}, 8'h00);
      wr(8'h08);
      @(posedge clk) evt <= 1'b1;
      @(posedge clk) evt <= 1'b0;
      wt(2);
      chk({7'h0, alrt}, 8'h01);
      wr(8'h09);
      chk({7'h0, alrt}, 8'h00);
      wr(8'h03);
      chk({7'h0, alrt}, 8'h01);
      @(posedge clk) lvl <= 1'b0;
      $display("test alert done");
   end
   endtask
   task t_trip;
   begin
      wr(8'h05);
      u_host.xfer(8'h83, 8'h5a, q);
      chk(lastwd, 8'h5a);
      chk({1'b0, lastad}, 8'h03);
      wt(500);
      chk({4'h0, nvi}, 8'h05);
      $display("test trip done");
   end
   endtask
   task t_wire;
   begin
      u_host.idle(1'b1);
      wt(2);
      wr(8'h0d);
      rdc(8'h00, 8'h0d);
      chk({6'h0, res}, 8'h02);
      u_host.idle(1'b0);
      @(posedge clk) mode <= 1'b0;
      wt(2);
      wr(8'h03);
      rdc(8'h00, 8'h03);
      chk({6'h0, res}, 8'h01);
      @(posedge clk) rdv <= 8'h3a;
      rdc(8'h01, 8'h3a);
      $display("test three wire done");
   end
   endtask
   task t_rerst;
   begin
      @(posedge clk) nrst <= 1'b0;
      wt(3);
      chk({7'h0, lp}, 8'h01);
      nrst <= 1'b1;
      wt(10);
      rdc(8'h00, 8'h01);
      chk({4'h0, nvi}, 8'h01);
      $display("test second reset done");
   end
   endtask
   task end_of_test;
   begin
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   initial
   begin
      wt(12);
      nrst <= 1'b1;
      wt(10);
      t_reset;
      t_res;
      t_cont;
      t_nv;
      t_alert;
      t_trip;
      t_wire;
      t_rerst;
      end_of_test;
   end
endmodule
